/* File: src/rcps_clock_ctrl.sv */
// Reference clock / PLL select control with AHB-Lite register slave
// Overview of operation
// RULE1 - PLL enable 0 uses direct reference; 1 enables PLL, VCO as clock.
// RULE2 - PLL multiplies by twice the feedback divider value, 20x to 510x.
// RULE3 - Software programs feedback divider between 10 and 255 only.
// RULE4 - Lock detector runs only when enabled; result shown in lock status.
// RULE5 - Divider path and doubler both 0 gives straight feedthrough.
// RULE6 - Feedthrough aligns to rising edge for 0, falling edge for 1.
// RULE7 - Divider path 1 wins over edge and doubler; 2-bit ratio field.
// RULE8 - Divided path always uses the inverted reference.
// RULE9 - Doubler 1 with divider path 0 doubles the reference.
// RULE10 - PLL input kept at or below 125 MHz; this controller does not check or limit it.
// RULE11 - Software starts VCO calibration only once the reference is stable.
// RULE12 - Software clears calibration bit before requesting the next one.
// RULE13 - VCO calibration completes before DAC clock calibration.
// RULE14 - Software pulses DAC calibration after power-up and clock changes.
// RULE15 - Charge pump current is automatic unless manual select is 1.
// RULE16 - Charge pump code 000..111 maps 125..1000 uA; resets to 011.
// RULE17 - Manual current is recommended to scale with N.
// RULE18 - Lock status reads 1 when PLL used, detector on and locked.
// RULE19 - Ratio codes: 00 off, 01 by 2, 10 by 4, 11 by 8.
// RULE20 - Lock status reads 0 if detector off or PLL bypassed; read-only.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module rcps_clock_ctrl (
	input  wire logic                    core_clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic                    hready,
	input  wire logic [31:0]             hwdata,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	input  wire logic                    pll_locked_i,
	input  wire logic                    osc_cal_done_i,
	input  wire logic [2:0]              cp_auto_code_i,
	output rcps_pkg::rcps_pll_ctrl_t     ctrl_o,
	output logic                         lock_status_o
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [31:0]               ctrl_one;
		logic [31:0]               clk_cfg;
		logic [2:0]                auto_cp;
		rcps_pkg::rcps_cal_state_t cal_state;
		logic                      cal_done;
		logic                      cal_prev;
		logic                      wr_pend;
		logic [2:0]                wr_sel;
		logic                      rd_pend;
		logic [2:0]                rd_sel;
		logic                      hready;
		logic [31:0]               hrdata;
		logic                      lock_sts;
		rcps_pkg::rcps_pll_ctrl_t  ctrl;
	} rcps_state_t;

	localparam rcps_state_t STATE_RST = '{
		ctrl_one: rcps_pkg::CTRL_ONE_RST,
		clk_cfg: rcps_pkg::CLK_PLL_RST,
		auto_cp: rcps_pkg::CP_CODE_RST,
		cal_state: rcps_pkg::CAL_IDLE,
		cal_done: 1'b0, cal_prev: 1'b0,
		wr_pend: 1'b0, wr_sel: 3'h0,
		rd_pend: 1'b0, rd_sel: 3'h0,
		hready: 1'b1, hrdata: 32'h00000000,
		lock_sts: 1'b0, ctrl: rcps_pkg::CTRL_RST};

	rcps_state_t s_reg;
	rcps_state_t s_next;

	rcps_pkg::rcps_route_t route_dec;
	logic                  invert_dec;
	logic [3:0]            div_dec;

	rcps_route_sel u_route (
		.clk_cfg_i    (s_reg.clk_cfg),
		.route_o      (route_dec),
		.ref_invert_o (invert_dec),
		.ref_div_o    (div_dec)
	);

	// ==========================================================
	// Address decode, one-hot over the three registers
	function automatic logic [2:0] reg_sel(input logic [31:0] addr);
		reg_sel = {addr == rcps_pkg::ADDR_LOCK_STS,
			addr == rcps_pkg::ADDR_CLK_PLL,
			addr == rcps_pkg::ADDR_CTRL_ONE};
	endfunction : reg_sel

	function automatic logic [31:0] read_word(input logic [2:0] sel,
		input rcps_state_t st);
		read_word = 32'h00000000;
		if (sel[0]) begin
			read_word = st.ctrl_one;
		end
		if (sel[1]) begin
			read_word = st.clk_cfg;
		end
		if (sel[2]) begin
			read_word[rcps_pkg::LOCK_STS_BIT] = st.lock_sts;
			read_word[rcps_pkg::CAL_DONE_BIT] = st.cal_done;
			read_word[rcps_pkg::CAL_BUSY_BIT] =
				st.cal_state == rcps_pkg::CAL_RUN;
		end
	endfunction : read_word

	// ==========================================================
	// Next state
	always_comb begin
		logic cal_bit;
		logic pll_en;
		cal_bit = s_reg.ctrl_one[rcps_pkg::CAL_START_BIT];
		pll_en  = s_reg.clk_cfg[rcps_pkg::PLL_EN_BIT];
		s_next  = s_reg;

		// Write data phase; reads wait one cycle so they see this write
		s_next.wr_pend = 1'b0;
		if (s_reg.wr_pend) begin
			if (s_reg.wr_sel[0]) begin
				s_next.ctrl_one = hwdata & rcps_pkg::CTRL_ONE_MASK;
			end
			if (s_reg.wr_sel[1]) begin
				s_next.clk_cfg = hwdata & rcps_pkg::CLK_PLL_MASK;
			end
			// Lock status index ignores writes: see RULE20
		end
		if (s_reg.rd_pend) begin
			s_next.hrdata  = read_word(s_reg.rd_sel, s_reg);
			s_next.hready  = 1'b1;
			s_next.rd_pend = 1'b0;
		end
		if (hsel && htrans[1] && hready) begin
			if (hwrite) begin
				s_next.wr_pend = 1'b1;
				s_next.wr_sel  = reg_sel(haddr);
			end else begin
				s_next.rd_pend = 1'b1;
				s_next.rd_sel  = reg_sel(haddr);
				s_next.hready  = 1'b0;
			end
		end

		// Derived PLL controls, one cycle behind the register
		s_next.ctrl.use_pll     = pll_en; // see RULE1
		s_next.ctrl.route       = route_dec; // see RULE5
		s_next.ctrl.ref_invert  = invert_dec;
		s_next.ctrl.ref_div     = div_dec;
		s_next.ctrl.fb_n        = s_reg.clk_cfg[rcps_pkg::FB_N_LSB +: 8];
		s_next.ctrl.mult        =
			{s_reg.clk_cfg[rcps_pkg::FB_N_LSB +: 8], 1'b0}; // see RULE2
		s_next.ctrl.lock_det_en =
			s_reg.clk_cfg[rcps_pkg::LOCK_DET_BIT]; // see RULE4
		s_next.ctrl.cp_manual   = s_reg.clk_cfg[rcps_pkg::CP_MAN_BIT];
		s_next.ctrl.cp_code     = s_reg.clk_cfg[rcps_pkg::CP_MAN_BIT]
			? s_reg.clk_cfg[rcps_pkg::CP_CODE_LSB +: 3]
			: s_reg.auto_cp; // see RULE15
		s_next.ctrl.cal_start   = 1'b0;

		// Detector result only counts with PLL in use and detector on
		s_next.lock_sts = pll_en && pll_locked_i &&
			s_reg.clk_cfg[rcps_pkg::LOCK_DET_BIT]; // see RULE18

		// VCO calibration sequence, started on a 0-to-1 of the bit while PLL enable is 1
		s_next.cal_prev = cal_bit;
		unique case (s_reg.cal_state)
			rcps_pkg::CAL_IDLE: begin
				if (cal_bit && !s_reg.cal_prev && pll_en) begin // see RULE12
					s_next.cal_state      = rcps_pkg::CAL_RUN;
					s_next.cal_done       = 1'b0;
					s_next.ctrl.cal_start = 1'b1;
				end
			end
			rcps_pkg::CAL_RUN: begin
				if (osc_cal_done_i) begin
					s_next.auto_cp   = cp_auto_code_i; // see RULE15
					s_next.cal_done  = 1'b1;
					s_next.cal_state = rcps_pkg::CAL_HOLD;
				end
			end
			rcps_pkg::CAL_HOLD: begin
				// A held bit never retriggers; software must clear it
				if (!cal_bit) begin
					s_next.cal_state = rcps_pkg::CAL_IDLE;
				end
			end
			default: begin
				s_next.cal_state = rcps_pkg::CAL_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s_reg <= STATE_RST; // see RULE16
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Outputs
	assign hreadyout     = s_reg.hready;
	assign hresp         = 1'b0;
	assign hrdata        = s_reg.hrdata;
	assign ctrl_o        = s_reg.ctrl;
	assign lock_status_o = s_reg.lock_sts;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_system_sample_clock_source: assert property ( // see RULE1
		ctrl_o.use_pll == $past(s_reg.clk_cfg[rcps_pkg::PLL_EN_BIT]))
		else $error("System clock source does not follow PLL enable");

	a_mult_even_n: assert property ( // see RULE2
		ctrl_o.mult == {ctrl_o.fb_n, 1'b0})
		else $error("PLL multiplication is not twice N");

	a_lock_gated: assert property ( // see RULE20
		lock_status_o |-> $past(pll_locked_i) &&
			$past(s_reg.clk_cfg[rcps_pkg::PLL_EN_BIT]) &&
			$past(s_reg.clk_cfg[rcps_pkg::LOCK_DET_BIT]))
		else $error("Lock status set while detector off or PLL bypassed");

	a_lock_reports: assert property ( // see RULE18
		pll_locked_i && s_reg.clk_cfg[rcps_pkg::PLL_EN_BIT] &&
		s_reg.clk_cfg[rcps_pkg::LOCK_DET_BIT] |=> lock_status_o)
		else $error("Lock not reported");

	a_feed_edge: assert property ( // see RULE6
		!s_reg.clk_cfg[rcps_pkg::DIV_PATH_BIT] &&
		!s_reg.clk_cfg[rcps_pkg::DBL_SEL_BIT] |=>
		ctrl_o.route == rcps_pkg::ROUTE_FEED &&
		ctrl_o.ref_invert == $past(s_reg.clk_cfg[rcps_pkg::EDGE_SEL_BIT]))
		else $error("Feedthrough route or edge wrong");

	a_div_inverted: assert property ( // see RULE8
		s_reg.clk_cfg[rcps_pkg::DIV_PATH_BIT] |=>
		ctrl_o.route == rcps_pkg::ROUTE_DIV && ctrl_o.ref_invert)
		else $error("Divided path not taken or not inverted");

	a_div_by_eight: assert property ( // see RULE19
		s_reg.clk_cfg[rcps_pkg::DIV_PATH_BIT] &&
		s_reg.clk_cfg[rcps_pkg::DIV_RATIO_LSB +: 2] == 2'h3 |=>
		ctrl_o.ref_div == 4'h8)
		else $error("Divide ratio code 11 not by 8");

	a_dbl_route: assert property ( // see RULE9
		s_reg.clk_cfg[rcps_pkg::DBL_SEL_BIT] &&
		!s_reg.clk_cfg[rcps_pkg::DIV_PATH_BIT] |=>
		ctrl_o.route == rcps_pkg::ROUTE_DBL)
		else $error("Doubler route not taken");

	a_cp_manual: assert property ( // see RULE15
		s_reg.clk_cfg[rcps_pkg::CP_MAN_BIT] |=>
		ctrl_o.cp_code == $past(s_reg.clk_cfg[rcps_pkg::CP_CODE_LSB +: 3]))
		else $error("Manual charge pump code not applied");

	a_cal_pulse: assert property ( // see RULE12
		ctrl_o.cal_start |-> s_reg.cal_state == rcps_pkg::CAL_RUN
		##1 !ctrl_o.cal_start)
		else $error("Calibration start is not a single pulse");

	c_div_route: cover property (ctrl_o.route == rcps_pkg::ROUTE_DIV);
	c_lock_seen: cover property ($rose(lock_status_o));
	c_cal_done:  cover property ($rose(s_reg.cal_done));
	c_read_wait: cover property (!hreadyout ##1 hreadyout);

endmodule : rcps_clock_ctrl

/* File: shared/rcps_pkg.sv */
// Constants and types for the reference clock and PLL select block
package rcps_pkg;

	// ==========================================================
	// Register indices and byte addresses (byte = index * 4)
	localparam logic [7:0]  IDX_CTRL_ONE  = 8'h00;
	localparam logic [7:0]  IDX_CLK_PLL   = 8'h02;
	localparam logic [7:0]  IDX_LOCK_STS  = 8'h1b;
	localparam logic [31:0] ADDR_CTRL_ONE = {22'h000000, IDX_CTRL_ONE, 2'h0};
	localparam logic [31:0] ADDR_CLK_PLL  = {22'h000000, IDX_CLK_PLL, 2'h0};
	localparam logic [31:0] ADDR_LOCK_STS = {22'h000000, IDX_LOCK_STS, 2'h0};

	// ==========================================================
	// Field positions
	localparam int unsigned CAL_START_BIT = 24;
	localparam int unsigned DIV_RATIO_LSB = 20;
	localparam int unsigned DBL_SEL_BIT   = 19;
	localparam int unsigned PLL_EN_BIT    = 18;
	localparam int unsigned DIV_PATH_BIT  = 17;
	localparam int unsigned EDGE_SEL_BIT  = 16;
	localparam int unsigned FB_N_LSB      = 8;
	localparam int unsigned CP_MAN_BIT    = 6;
	localparam int unsigned CP_CODE_LSB   = 3;
	localparam int unsigned LOCK_DET_BIT  = 2;
	localparam int unsigned LOCK_STS_BIT  = 24;
	localparam int unsigned CAL_DONE_BIT  = 1;
	localparam int unsigned CAL_BUSY_BIT  = 0;

	// ==========================================================
	// Reset values and writable masks
	localparam logic [7:0]  FB_N_RST      = 8'h0a;
	localparam logic [2:0]  CP_CODE_RST   = 3'h3;
	localparam logic [31:0] CTRL_ONE_RST  = 32'h00000000;
	localparam logic [31:0] CLK_PLL_RST   = {16'h0000, FB_N_RST, 2'h0,
		CP_CODE_RST, 3'h0};
	localparam logic [31:0] CTRL_ONE_MASK = 32'h01000000;
	localparam logic [31:0] CLK_PLL_MASK  = 32'h003fff7c;
	localparam logic [3:0]  DIV_BY_ONE    = 4'h1;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		ROUTE_FEED = 3'h1,
		ROUTE_DIV  = 3'h2,
		ROUTE_DBL  = 3'h4
	} rcps_route_t;

	typedef enum logic [2:0] {
		CAL_IDLE = 3'h1,
		CAL_RUN  = 3'h2,
		CAL_HOLD = 3'h4
	} rcps_cal_state_t;

	typedef struct packed {
		logic        use_pll;
		rcps_route_t route;
		logic        ref_invert;
		logic [3:0]  ref_div;
		logic [7:0]  fb_n;
		logic [8:0]  mult;
		logic        lock_det_en;
		logic        cp_manual;
		logic [2:0]  cp_code;
		logic        cal_start;
	} rcps_pll_ctrl_t;

	localparam rcps_pll_ctrl_t CTRL_RST = '{use_pll: 1'b0,
		route: ROUTE_FEED, ref_invert: 1'b0, ref_div: DIV_BY_ONE,
		fb_n: FB_N_RST, mult: {FB_N_RST, 1'b0}, lock_det_en: 1'b0,
		cp_manual: 1'b0, cp_code: CP_CODE_RST, cal_start: 1'b0};

endpackage : rcps_pkg

/* File: src/rcps_route_sel.sv */
// Decoder for the reference routing into the PLL input
`timescale 1ns/1ps
module rcps_route_sel (
	input  wire logic [31:0]          clk_cfg_i,
	output rcps_pkg::rcps_route_t     route_o,
	output logic                      ref_invert_o,
	output logic [3:0]                ref_div_o
);

	// ==========================================================
	// Divider ratio code
	function automatic logic [3:0] div_ratio(input logic [1:0] code);
		unique case (code)
			2'h0: div_ratio = rcps_pkg::DIV_BY_ONE;
			2'h1: div_ratio = 4'h2;
			2'h2: div_ratio = 4'h4;
			2'h3: div_ratio = 4'h8;
		endcase
	endfunction : div_ratio

	// ==========================================================
	// Path selection: divided path outranks the doubler and edge bits
	always_comb begin
		route_o      = rcps_pkg::ROUTE_FEED;
		ref_invert_o = clk_cfg_i[rcps_pkg::EDGE_SEL_BIT]; // see RULE6
		ref_div_o    = rcps_pkg::DIV_BY_ONE;
		if (clk_cfg_i[rcps_pkg::DIV_PATH_BIT]) begin // see RULE7
			route_o      = rcps_pkg::ROUTE_DIV;
			ref_invert_o = 1'b1; // see RULE8
			ref_div_o    = div_ratio(
				clk_cfg_i[rcps_pkg::DIV_RATIO_LSB +: 2]); // see RULE19
		end else if (clk_cfg_i[rcps_pkg::DBL_SEL_BIT]) begin // see RULE9
			route_o      = rcps_pkg::ROUTE_DBL;
			ref_invert_o = 1'b0;
		end
	end

endmodule : rcps_route_sel

/* File: bench/rcps_pll_model.sv */
// Behavioural model of the analog PLL and VCO calibration behind the block
`timescale 1ns/1ps
module rcps_pll_model #(
	parameter logic [2:0] AUTO_CODE = 3'h5
) (
	input  wire logic               core_clk_i,
	input  wire logic               rst_n_i,
	input  wire logic               slow_i,
	input  rcps_pkg::rcps_pll_ctrl_t ctrl_i,
	output logic                    locked_o,
	output logic                    cal_done_o,
	output logic [2:0]              cp_code_o
);
	// ==========================================================
	// Calibration run and lock
	logic       run_reg;
	logic [3:0] cnt_reg;

	// Code is only meaningful with done; otherwise show a wrong value
	assign cp_code_o = cal_done_o ? AUTO_CODE : ~AUTO_CODE;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			run_reg    <= 1'b0;
			cnt_reg    <= 4'h0;
			cal_done_o <= 1'b0;
			locked_o   <= 1'b0;
		end else begin
			cal_done_o <= 1'b0;
			if (ctrl_i.cal_start) begin
				run_reg  <= 1'b1;
				cnt_reg  <= slow_i ? 4'h8 : 4'h2;
				locked_o <= 1'b0;
			end else if (run_reg) begin
				cnt_reg <= cnt_reg - 4'h1;
				if (cnt_reg == 4'h1) begin
					run_reg    <= 1'b0;
					cal_done_o <= 1'b1;
					locked_o   <= ctrl_i.use_pll;
				end
			end
			// Lock is lost as soon as the loop is switched off
			if (!ctrl_i.use_pll) begin
				locked_o <= 1'b0;
			end
		end
	end
endmodule : rcps_pll_model

/* File: bench/ref_clock_pll_select_tb.sv */
// Self-checking bench for the reference clock and PLL select block
`timescale 1ns/1ps
module ref_clock_pll_select_tb;
	// ==========================================================
	// Signals
	logic                     clk;
	logic                     rst_n;
	logic                     hsel;
	logic [31:0]              haddr;
	logic [1:0]               htrans;
	logic                     hwrite;
	logic [2:0]               hsize;
	logic [31:0]              hwdata;
	logic                     hreadyout;
	logic                     hresp;
	logic [31:0]              hrdata;
	logic                     locked;
	logic                     cal_done;
	logic                     slow;
	logic [2:0]               auto_code;
	rcps_pkg::rcps_pll_ctrl_t ctrl;
	logic                     lock_sts;
	logic [31:0]              rd;
	int                       err_total;
	int                       tests_run;

	always #10 clk = ~clk;

	rcps_clock_ctrl i_rcps_clock_ctrl (
		.core_clk_i(clk), .rst_n_i(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pll_locked_i(locked),
		.osc_cal_done_i(cal_done), .cp_auto_code_i(auto_code),
		.ctrl_o(ctrl), .lock_status_o(lock_sts));

	rcps_pll_model i_rcps_pll_model (
		.core_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .ctrl_i(ctrl),
		.locked_o(locked), .cal_done_o(cal_done), .cp_code_o(auto_code));

	// ==========================================================
	// Shared tasks
	task automatic close_out;
		if (err_total == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// One single AHB transfer; hold each phase until hready is seen high
	task automatic ahb(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : ahb

	task automatic chk_rt(input logic [2:0] rt, input logic inv,
		input logic [3:0] dv);
		repeat (2) @(posedge clk);
		chk(32'({ctrl.route, ctrl.ref_invert, ctrl.ref_div}),
			32'({rt, inv, dv}));
	endtask : chk_rt

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		ahb(1'b0, rcps_pkg::ADDR_CLK_PLL, 32'h0);
		chk(rd, 32'h00000a18);
		ahb(1'b0, rcps_pkg::ADDR_CTRL_ONE, 32'h0);
		chk(rd, 32'h00000000);
		chk(32'(ctrl.use_pll), 32'h0);
		chk(32'(ctrl.mult), 32'h14);
		chk(32'(ctrl.cp_code), 32'h3);
		chk_rt(rcps_pkg::ROUTE_FEED, 1'b0, 4'h1);
	endtask : t_reset

	task automatic t_route;
		ahb(1'b1, rcps_pkg::ADDR_CLK_PLL, 32'h00010a18);
		chk_rt(rcps_pkg::ROUTE_FEED, 1'b1, 4'h1);
		ahb(1'b1, rcps_pkg::ADDR_CLK_PLL, 32'h00090a18);
		chk_rt(rcps_pkg::ROUTE_DBL, 1'b0, 4'h1);
		// Divided path must win even with edge and doubler bits set
		for (int r = 0; r < 4; r++) begin
			ahb(1'b1, rcps_pkg::ADDR_CLK_PLL, 32'h000b0a18 | (r << 20));
			chk_rt(rcps_pkg::ROUTE_DIV, 1'b1, 4'h1 << r);
		end
		ahb(1'b1, rcps_pkg::ADDR_CLK_PLL, 32'hffffffff);
		ahb(1'b0, rcps_pkg::ADDR_CLK_PLL, 32'h0);
		chk(rd, 32'h003fff7c);
		repeat (2) @(posedge clk);
		chk(32'(ctrl.mult), 32'h1fe);
		chk(32'(ctrl.cp_code), 32'h7);
		chk(32'(ctrl.use_pll), 32'h1);
		chk(32'(ctrl.fb_n), 32'hff);
		chk(32'(ctrl.lock_det_en), 32'h1);
		chk(32'(ctrl.cp_manual), 32'h1);
		// Manual code scaled to a low N: lowest current for N of 12
		ahb(1'b1, rcps_pkg::ADDR_CLK_PLL, 32'h00000c40);
		repeat (2) @(posedge clk);
		chk(32'(ctrl.cp_code), 32'h0);
		chk(32'(ctrl.mult), 32'h18);
	endtask : t_route

	task automatic t_lock_cal;
		ahb(1'b1, rcps_pkg::ADDR_CLK_PLL, 32'h00040a18);
		ahb(1'b1, rcps_pkg::ADDR_CTRL_ONE, 32'h01000000);
		repeat (10) @(posedge clk);
		ahb(1'b0, rcps_pkg::ADDR_LOCK_STS, 32'h0);
		chk(rd, 32'h00000002);
		chk(32'(ctrl.cp_code), 32'h5);
		ahb(1'b1, rcps_pkg::ADDR_CLK_PLL, 32'h00040a1c);
		repeat (3) @(posedge clk);
		ahb(1'b1, rcps_pkg::ADDR_LOCK_STS, 32'h0);
		chk(32'(hresp), 32'h0);
		ahb(1'b0, rcps_pkg::ADDR_LOCK_STS, 32'h0);
		chk(rd, 32'h01000002);
		chk(32'(lock_sts), 32'h1);
		// Second calibration with a slow loop, so busy can be caught
		slow <= 1'b1;
		ahb(1'b1, rcps_pkg::ADDR_CTRL_ONE, 32'h0);
		ahb(1'b1, rcps_pkg::ADDR_CTRL_ONE, 32'h01000000);
		repeat (3) @(posedge clk);
		ahb(1'b0, rcps_pkg::ADDR_LOCK_STS, 32'h0);
		chk(rd, 32'h00000001);
		repeat (20) @(posedge clk);
		ahb(1'b0, rcps_pkg::ADDR_LOCK_STS, 32'h0);
		chk(rd, 32'h01000002);
		// DAC timing pulse goes after the oscillator run; lies outside here
		ahb(1'b1, 32'h0000000c, 32'h01000000);
		ahb(1'b1, 32'h0000000c, 32'h0);
		ahb(1'b0, 32'h0000000c, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b1, rcps_pkg::ADDR_CLK_PLL, 32'h00000a1c);
		repeat (3) @(posedge clk);
		ahb(1'b0, rcps_pkg::ADDR_LOCK_STS, 32'h0);
		chk(rd, 32'h00000002);
		chk(32'(ctrl.use_pll), 32'h0);
	endtask : t_lock_cal

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		clk       = 1'b0;
		rst_n     = 1'b0;
		hsel      = 1'b0;
		haddr     = 32'h0;
		htrans    = 2'h0;
		hwrite    = 1'b0;
		hsize     = 3'h2;
		hwdata    = 32'h0;
		slow      = 1'b0;
		err_total = 0;
		tests_run = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_route();
		t_lock_cal();
		close_out();
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		close_out();
	end
endmodule : ref_clock_pll_select_tb
